// File: hw/lamp_display_pkg.sv
// Shared constants and types for the serial lamp display shifter
package lamp_display_pkg;

    // Shift chain geometry
    localparam int STAGE_COUNT     = 80;
    localparam int GROUP_WIDTH     = 8;
    localparam int DIGIT_COUNT     = 9;
    localparam int INDICATOR_COUNT = 8;

    // Offset of a segment within its eight-stage group once the group is placed
    localparam int SEGMENT_A     = 0;
    localparam int SEGMENT_B     = 1;
    localparam int SEGMENT_C     = 2;
    localparam int SEGMENT_D     = 3;
    localparam int SEGMENT_E     = 4;
    localparam int SEGMENT_F     = 5;
    localparam int SEGMENT_G     = 6;
    localparam int SEGMENT_POINT = 7;

    // Stage offset inside the indicator group for indicators 1 to 8
    localparam int INDICATOR_STAGE [INDICATOR_COUNT] = '{2, 1, 7, 6, 4, 5, 0, 3};

    // A stage at one leaves its lamp dark
    localparam logic LAMP_DARK = 1'b1;

    // Link must stay still this long before the pattern is taken over
    localparam int CLOCK_PERIOD_NS = 25;
    localparam int QUIET_TIME_NS   = 100;
    localparam int QUIET_CYCLES    = (QUIET_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int QUIET_WIDTH     = $clog2(QUIET_CYCLES + 1);

    localparam int BUFFER_DEPTH = 2;

    // Active-low lamp drive; digit_n[k] is digit k+1, indicator_n[i] is indicator i+1
    typedef struct packed {
        logic [DIGIT_COUNT-1:0][GROUP_WIDTH-1:0] digit_n;
        logic [INDICATOR_COUNT-1:0]              indicator_n;
    } lamp_word_type;

    localparam int LAMP_WIDTH = $bits(lamp_word_type);

endpackage : lamp_display_pkg

// File: hw/lamp_buffer.sv
// Small valid/ready buffer holding display patterns between capture and lamp drive
`timescale 1ns/100ps
module lamp_buffer #(
    parameter int WIDTH = lamp_display_pkg::LAMP_WIDTH,
    parameter int DEPTH = lamp_display_pkg::BUFFER_DEPTH
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic             fill_valid,
    output logic                  fill_ready,
    input  wire logic [WIDTH-1:0] fill_data,
    output logic                  drain_valid,
    input  wire logic             drain_ready,
    output logic      [WIDTH-1:0] drain_data
);
    import lamp_display_pkg::*;

    localparam int POINTER_WIDTH = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int COUNT_WIDTH   = $clog2(DEPTH + 1);
    localparam logic [POINTER_WIDTH-1:0] LAST_SLOT = POINTER_WIDTH'(DEPTH - 1);
    localparam logic [COUNT_WIDTH-1:0]   FULL      = COUNT_WIDTH'(DEPTH);

    logic [WIDTH-1:0]         slot      [DEPTH];
    logic [WIDTH-1:0]         next_slot [DEPTH];
    logic [POINTER_WIDTH-1:0] write_pointer;
    logic [POINTER_WIDTH-1:0] next_write_pointer;
    logic [POINTER_WIDTH-1:0] read_pointer;
    logic [POINTER_WIDTH-1:0] next_read_pointer;
    logic [COUNT_WIDTH-1:0]   count;
    logic [COUNT_WIDTH-1:0]   next_count;
    logic                     push;
    logic                     pop;

    assign fill_ready  = (count != FULL);
    assign drain_valid = (count != '0);
    assign drain_data  = slot[read_pointer];
    assign push        = fill_valid & fill_ready;
    assign pop         = drain_valid & drain_ready;

    always_comb begin
        next_slot          = slot;
        next_write_pointer = write_pointer;
        next_read_pointer  = read_pointer;
        next_count         = count;
        if (push) begin
            next_slot[write_pointer] = fill_data;
            next_write_pointer       = (write_pointer == LAST_SLOT) ? '0 : write_pointer + 1'b1;
        end
        if (pop) begin
            next_read_pointer = (read_pointer == LAST_SLOT) ? '0 : read_pointer + 1'b1;
        end
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        slot <= next_slot;
        if (!reset_n) begin
            write_pointer <= '0;
            read_pointer  <= '0;
            count         <= '0;
        end else begin
            write_pointer <= next_write_pointer;
            read_pointer  <= next_read_pointer;
            count         <= next_count;
        end
    end

endmodule : lamp_buffer

// File: hw/serial_led_display_shifter.sv
// Serial-in lamp shift chain with its display pattern carried to the system clock
//
// Overview of operation
// - An 80-stage shift chain holds one stage per segment, decimal point and indicator lamp.
// - The stages form nine digits of eight stages (seven segments and a point) plus eight indicators.
// - Only a rising edge of the shift clock takes the data bit and advances the chain by one.
// - On each shift every stage takes its predecessor's old value, so the chain moves as one.
// - Bits enter through the indicator group first, then digit nine, and digit one is deepest.
// - Within a group bits map in entry order to point, g, f, e, d, c, b, a, or indicators 3,4,6,5,8,1,2,7.
// - A stage at zero lights its lamp and a stage at one leaves it dark.
// - The lamp pattern stays static with no refresh until new bits are shifted in.
`timescale 1ns/100ps
module serial_led_display_shifter (
    input  wire logic                            clock,
    input  wire logic                            reset_n,
    input  wire logic                            shift_clock,
    input  wire logic                            shift_data,
    output logic                                 lamp_valid,
    input  wire logic                            lamp_ready,
    output lamp_display_pkg::lamp_word_type      lamp
);
    import lamp_display_pkg::*;

    // Link side, clocked by the host's shift clock
    logic [STAGE_COUNT-1:0] stage;
    logic [STAGE_COUNT-1:0] next_stage;
    logic                   link_reset_meta;
    logic                   link_reset_n;
    logic                   shift_toggle;
    logic                   next_shift_toggle;

    // System side
    logic                   toggle_meta;
    logic                   toggle_sync;
    logic                   toggle_prev;
    logic                   changed;
    logic [QUIET_WIDTH-1:0] quiet;
    logic [QUIET_WIDTH-1:0] next_quiet;
    logic                   quiet_done;
    logic                   pending;
    logic                   next_pending;
    logic                   push;
    logic                   fill_ready;
    lamp_word_type          snapshot;
    lamp_word_type          drain_data;
    lamp_word_type          next_lamp;

    always_comb begin
        next_stage = {stage[STAGE_COUNT-2:0], shift_data};
    end

    // Chain carries no reset: only shifted bits change it
    always_ff @(posedge shift_clock) begin
        stage <= next_stage;
    end

    // Each shift outside link reset flips a toggle that tells the system side the link moved
    always_comb begin
        next_shift_toggle = link_reset_n ? ~shift_toggle : 1'b0;
    end

    always_ff @(posedge shift_clock) begin
        link_reset_meta <= reset_n;
        link_reset_n    <= link_reset_meta;
        shift_toggle    <= next_shift_toggle;
    end

    // Toggle crossing; only toggle_sync and later stages are examined
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            toggle_meta <= 1'b0;
            toggle_sync <= 1'b0;
            toggle_prev <= 1'b0;
        end else begin
            toggle_meta <= shift_toggle;
            toggle_sync <= toggle_meta;
            toggle_prev <= toggle_sync;
        end
    end

    assign changed    = toggle_sync ^ toggle_prev;
    assign quiet_done = (quiet == QUIET_WIDTH'(QUIET_CYCLES));
    assign push       = pending & quiet_done & fill_ready;

    always_comb begin
        if (changed) begin
            next_quiet = '0;
        end else if (quiet_done) begin
            next_quiet = quiet;
        end else begin
            next_quiet = quiet + 1'b1;
        end
        // A new shift wins over the clear by a push
        next_pending = changed | (pending & ~push);
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            quiet   <= '0;
            pending <= 1'b0;
        end else begin
            quiet   <= next_quiet;
            pending <= next_pending;
        end
    end

    genvar k;
    generate
        for (k = 0; k < DIGIT_COUNT; k++) begin : gen_digit
            assign snapshot.digit_n[k] = stage[GROUP_WIDTH*(DIGIT_COUNT-k) +: GROUP_WIDTH];
        end
        for (k = 0; k < INDICATOR_COUNT; k++) begin : gen_indicator
            assign snapshot.indicator_n[k] = stage[INDICATOR_STAGE[k]];
        end
    endgenerate

    // Chain is still while quiet_done holds, so the wide snapshot is stable when taken
    lamp_buffer #(
        .WIDTH (LAMP_WIDTH),
        .DEPTH (BUFFER_DEPTH)
    ) pattern_buffer (
        .clock       (clock),
        .reset_n     (reset_n),
        .fill_valid  (push),
        .fill_ready  (fill_ready),
        .fill_data   (snapshot),
        .drain_valid (lamp_valid),
        .drain_ready (lamp_ready),
        .drain_data  (drain_data)
    );

    always_comb begin
        next_lamp = (lamp_valid && lamp_ready) ? drain_data : lamp;
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            lamp <= {LAMP_WIDTH{LAMP_DARK}};
        end else begin
            lamp <= next_lamp;
        end
    end

endmodule : serial_led_display_shifter

// File: sim/lamp_display_props.sv
// Checker on the lamp display shifter ports
`timescale 1ns/100ps
module lamp_display_props (
    input wire logic                           clock,
    input wire logic                           reset_n,
    input wire logic                           shift_clock,
    input wire logic                           shift_data,
    input wire logic                           lamp_valid,
    input wire logic                           lamp_ready,
    input wire lamp_display_pkg::lamp_word_type lamp
);
    import lamp_display_pkg::*;
    logic       last_clk;
    logic [3:0] quiet;
    logic [3:0] next_quiet;
    // Clocks since the link was last seen to move
    always_comb begin
        next_quiet = (!reset_n || shift_clock != last_clk) ? 4'h0 : quiet + {3'h0, quiet != 4'hf};
    end
    always_ff @(posedge clock) begin
        last_clk <= shift_clock;
        quiet    <= next_quiet;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_release_dark: assert property ($rose(reset_n) |-> lamp == '1) else $error("lamp lit after reset");
    a_release_idle: assert property ($rose(reset_n) |-> !lamp_valid) else $error("valid after reset");
    a_lamp_hold: assert property (!(lamp_valid && lamp_ready) |=> $stable(lamp)) else $error("lamp moved");
    a_change_cause: assert property ($changed(lamp) |-> $past(lamp_ready)) else $error("lamp moved unasked");
    a_stall_hold: assert property (lamp_valid && !lamp_ready |=> lamp_valid) else $error("pattern lost");
    a_drain_burst: assert property ((lamp_valid && lamp_ready) [*3] |=> !lamp_valid) else $error("extra word");
    a_quiet_push: assert property ($rose(lamp_valid) |-> quiet >= 4'h3) else $error("taken mid shift");
    a_idle_stays: assert property ((!lamp_valid && quiet == 4'hf) [*3] |=> !lamp_valid) else $error("ghost word");
    c_stall: cover property (lamp_valid && !lamp_ready);
    c_burst: cover property ((lamp_valid && lamp_ready) [*3]);
    c_push: cover property ($rose(lamp_valid));
endmodule : lamp_display_props

// File: sim/lamp_host_model.sv
// Host port model shifting bits over the link
`timescale 1ns/100ps
module lamp_host_model (
    output logic shift_clock,
    output logic shift_data
);
    initial begin
        shift_clock = 1'b0;
        shift_data  = 1'b1;
    end
    // Sends the low n bits of f, highest first
    task automatic send(input logic [79:0] f, input int n);
        for (int k = n - 1; k >= 0; k--) begin
            // fixed bit period of 15 ns
            shift_data = f[k];
            #7.5 shift_clock = 1'b1;
            #7.5 shift_clock = 1'b0;
        end
        shift_data = ~shift_data;
    endtask : send
endmodule : lamp_host_model

// File: sim/serial_led_display_shifter_tb.sv
// Self-checking bench for the serial lamp display shifter
`timescale 1ns/100ps
module serial_led_display_shifter_tb;
    import lamp_display_pkg::*;
    logic          clock, reset_n, lamp_ready, lamp_valid, shift_clock, shift_data;
    lamp_word_type lamp;
    logic [79:0]   chain;
    lamp_word_type q[$];
    int            errors, total_checks;
    serial_led_display_shifter dut_u (.clock(clock), .reset_n(reset_n), .shift_clock(shift_clock),
        .shift_data(shift_data), .lamp_valid(lamp_valid), .lamp_ready(lamp_ready), .lamp(lamp));
    lamp_host_model host_u (.shift_clock(shift_clock), .shift_data(shift_data));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    function automatic lamp_word_type expect_lamp(input logic [79:0] s);
        lamp_word_type w;
        for (int d = 1; d <= DIGIT_COUNT; d++) w.digit_n[d-1] = s[8*(10-d) +: 8];
        for (int i = 0; i < INDICATOR_COUNT; i++) w.indicator_n[i] = s[INDICATOR_STAGE[i]];
        return w;
    endfunction : expect_lamp
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    task automatic chk(input lamp_word_type e);
        total_checks++;
        if (lamp !== e) begin
            errors++;
            $display("Error lamp expected %h seen %h", e, lamp);
        end
    endtask : chk
    // Shift n bits, model the chain, then pause for capture
    task automatic shift(input logic [79:0] f, input int n);
        host_u.send(f, n);
        chain = (chain << n) | (f & ((80'h1 << n) - 80'h1));
        q.push_back(expect_lamp(chain));
        repeat (12) @(negedge clock);
    endtask : shift
    task automatic take();
        int t;
        t = 0;
        lamp_ready = 1'b1;
        while (lamp_valid !== 1'b1 && t < 40) begin
            @(negedge clock);
            t++;
        end
        if (lamp_valid !== 1'b1) begin
            errors++;
            $display("Error lamp_valid expected 1 seen %b", lamp_valid);
            end_sim();
        end
        @(negedge clock);
        chk(q.pop_front());
        // Stall the drain again so the next pattern waits in the buffer for its own take
        lamp_ready = 1'b0;
        @(negedge clock);
    endtask : take
    initial begin
        errors = 0;
        total_checks = 0;
        chain = '0;
        reset_n = 1'b0;
        lamp_ready = 1'b0;
        void'($urandom(23));
        host_u.send(80'h0, 8);
        repeat (2) @(negedge clock);
        reset_n = 1'b1;
        @(negedge clock);
        chk('1);
        total_checks++;
        if (lamp_valid !== 1'b0) begin
            errors++;
            $display("Error lamp_valid expected 0 seen %b", lamp_valid);
        end
        foreach (q[i]) q.delete();
        shift(80'h0, 80); take();
        shift('1, 80); take();
        shift(80'h1, 80); take();
        for (int k = 0; k < 8; k++) begin
            shift({16'($urandom()), $urandom(), $urandom()}, 80); take();
        end
        for (int k = 0; k < 10; k++) begin
            shift({16'($urandom()), $urandom(), $urandom()}, 8 * (k + 1)); take();
            lamp_ready = 1'b0;
        end
        for (int k = 0; k < 3; k++) shift({16'($urandom()), $urandom(), $urandom()}, 80);
        take(); take(); take();
        repeat (30) @(negedge clock);
        chk(expect_lamp(chain));
        end_sim();
    end
endmodule : serial_led_display_shifter_tb
bind serial_led_display_shifter lamp_display_props props_u (.clock(clock), .reset_n(reset_n),
    .shift_clock(shift_clock), .shift_data(shift_data), .lamp_valid(lamp_valid),
    .lamp_ready(lamp_ready), .lamp(lamp));
